// [cc_match_pkg.sv]
// constants and types for the threshold match status block
package cc_match_pkg;
    // register addresses, 12 bits wide
    localparam logic [11:0] ADDR_HW_CTL = 12'h800;
    localparam logic [11:0] ADDR_SUMMARY = 12'h803;
    localparam logic [11:0] ADDR_CHG1 = 12'h804;
    localparam logic [11:0] ADDR_CHG2 = 12'h805;
    localparam logic [11:0] ADDR_HITS1 = 12'h806;
    localparam logic [11:0] ADDR_HITS2 = 12'h807;
    // hardware control field positions
    localparam int POS_PAUSE = 12;
    localparam int POS_UNIT = 11;
    localparam int POS_DB_ACTIVE = 9;
    localparam int POS_ATTACHED = 8;
    // summary field positions
    localparam int POS_FIRST_VALID = 7;
    localparam int POS_PIN2_CHG = 1;
    localparam int POS_PIN1_CHG = 0;
    // reset values
    localparam logic PAUSE_RST = 1'b0;
    localparam logic UNIT_RST = 1'b0;
    localparam logic [7:0] SPARE_RST = 8'h00;
    localparam logic [7:0] CHG_RST = 8'h00;
    localparam logic [7:0] HITS_RST = 8'h00;
    localparam logic [15:0] RD_NONE = 16'h0000;
    // timing: clock period and the two settle units
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCAN_TIME_NS = 1600000;
    localparam int FINE_TIME_NS = 100000;
    localparam int SCAN_CYC = SCAN_TIME_NS / CLK_PERIOD_NS;
    localparam int FINE_CYC = FINE_TIME_NS / CLK_PERIOD_NS;
    // attachment state from the connection detect logic
    typedef enum logic [3:0] {
        ATT_UNATTACHED = 4'b0001,
        ATT_WAIT = 4'b0010,
        ATT_SOURCE = 4'b0100,
        ATT_SINK = 4'b1000
    } attach_t;
endpackage

// [settle_filter.sv]
// per-pin settle filter for the eight threshold comparator results
`timescale 1ns/1ps
module settle_filter (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic enable,
    input wire logic pause,
    input wire logic hold,
    input wire logic tick,
    input wire logic [7:0] limit,
    input wire logic [7:0] filterEn,
    input wire logic [7:0] raw,
    output logic [7:0] hits,
    output logic settled
);
    import cc_match_pkg::*;

    logic [7:0] stable_r; // last settled value of filtered bits
    logic [7:0] cnt_r; // settle units elapsed on a pending change
    logic [7:0] hits_r; // presented match result
    logic settled_r; // one-cycle pulse from the edge of a settled load
    logic differ; // filtered bits disagree with settled value

    assign differ = (raw & filterEn) != (stable_r & filterEn);

    // count whole units while a change persists, then accept it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stable_r <= HITS_RST;
            cnt_r <= 8'h00;
            settled_r <= 1'b0;
        end else if (ce) begin
            settled_r <= 1'b0;
            // unfiltered bits track the pin, so turning a filter on
            // later does not drop a level that is already present
            stable_r <= (stable_r & filterEn) | (raw & ~filterEn);
            if (!enable || !differ || !hold) begin
                // change gone or gate closed: start over
                cnt_r <= 8'h00;
            end else if (tick && !pause) begin
                if (cnt_r >= limit) begin
                    // elapsed time is the limit plus one, times unit
                    stable_r <= raw;
                    cnt_r <= 8'h00;
                    settled_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    end

    // filtered bits show settled value, others show raw result
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hits_r <= HITS_RST;
        end else if (ce) begin
            if (enable) begin
                hits_r <= (stable_r & filterEn) | (raw & ~filterEn);
            end
        end
    end

    assign hits = hits_r;
    assign settled = settled_r;
endmodule

// [cc_match_status.sv]
// threshold match status and hardware control registers
`timescale 1ns/1ps
module cc_match_status #(
    // cycles per full threshold scan; shorten for simulation
    parameter int SCAN_CYCLES = cc_match_pkg::SCAN_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // host register port
    input wire logic [11:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    // asynchronous comparator results, one bit per threshold
    input wire logic [7:0] pin1Compare,
    input wire logic [7:0] pin2Compare,
    // same-clock inputs from neighbouring blocks
    input wire logic compEnable,
    input wire logic messageBusy,
    input wire logic openSeen,
    input wire cc_match_pkg::attach_t attachState,
    input wire logic [7:0] unattachedSettleTime,
    input wire logic [7:0] messageSettleTime,
    input wire logic [7:0] settleFilterEnable1,
    input wire logic [7:0] settleFilterEnable2,
    // control bits toward the rest of the device
    output logic pauseOnMessage,
    output logic debouncerActive
);
    import cc_match_pkg::*;

    // control register fields
    logic pauseOnMessage_r; // pause debouncer on message traffic
    logic unitSel_r; // match debounce unit select
    logic [7:0] spare_r; // low byte, read/write storage only

    // synchronisers for the comparator pins
    logic [7:0] p1Meta_r; // first stage, read only by second
    logic [7:0] p1Sync_r;
    logic [7:0] p2Meta_r; // first stage, read only by second
    logic [7:0] p2Sync_r;

    // tick dividers
    logic [15:0] scanCnt_r; // counts one full scan
    logic [11:0] fineCnt_r; // counts one fine unit
    logic scanTick; // one cycle per full scan
    logic fineTick; // one cycle per fine unit

    // settle selection by attach state
    logic unitTick; // tick in the chosen unit
    logic [7:0] limit; // count limit in the chosen unit
    logic holdGate; // gate that must persist while counting
    logic pauseNow; // debouncer paused this cycle

    // filter results
    logic [7:0] hits1; // pin 1 presented result
    logic [7:0] hits2; // pin 2 presented result
    logic settled1; // pin 1 settled load
    logic settled2; // pin 2 settled load
    logic [7:0] hits1Prev_r; // previous pin 1 result
    logic [7:0] hits2Prev_r; // previous pin 2 result

    // status
    logic [7:0] chg1_r; // pin 1 change status
    logic [7:0] chg2_r; // pin 2 change status
    logic [7:0] chg1_nxt;
    logic [7:0] chg2_nxt;
    logic firstValid_r; // first result valid after enable
    logic attached_r; // attach state seen by software
    logic dbActive_r; // debouncer running
    logic [15:0] rdData_r; // registered read answer
    logic [15:0] rdMux; // combinational read select

    // true when a write hits the given address
    // no ce here; every user sits behind its own ce gate
    function automatic logic wrHit(input logic [11:0] a);
        wrHit = regWrEn && (regAddr == a);
    endfunction

    // match value as seen by a read: default while disabled
    function automatic logic [7:0] hitsView(input logic [7:0] h);
        hitsView = compEnable ? h : HITS_RST;
    endfunction

    // control register: pause and unit bits plus spare byte
    // reserved high bits are not stored; writes to them are lost
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pauseOnMessage_r <= PAUSE_RST;
            unitSel_r <= UNIT_RST;
            spare_r <= SPARE_RST;
        end else if (ce) begin
            if (wrHit(ADDR_HW_CTL)) begin
                pauseOnMessage_r <= regWrData[POS_PAUSE];
                unitSel_r <= regWrData[POS_UNIT];
                spare_r <= regWrData[7:0];
            end
        end
    end

    // two flops before any logic looks at the comparator pins
    // comparators switch on their own timing, hence the pair
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            p1Meta_r <= HITS_RST;
            p1Sync_r <= HITS_RST;
            p2Meta_r <= HITS_RST;
            p2Sync_r <= HITS_RST;
        end else if (ce) begin
            p1Meta_r <= pin1Compare;
            p1Sync_r <= p1Meta_r;
            p2Meta_r <= pin2Compare;
            p2Sync_r <= p2Meta_r;
        end
    end

    // scan divider: one tick per full pass over all thresholds
    // the coarse unit is this tick, free running while enabled;
    // a settle time so carries up to one unit of phase error,
    // traded for one divider shared by both pins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scanCnt_r <= 16'h0000;
        end else if (ce) begin
            if (!compEnable || scanTick) begin
                scanCnt_r <= 16'h0000;
            end else begin
                scanCnt_r <= scanCnt_r + 16'h0001;
            end
        end
    end

    // fine divider for the 100 us unit
    // fixed length; it does not follow SCAN_CYCLES
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fineCnt_r <= 12'h000;
        end else if (ce) begin
            if (!compEnable || fineTick) begin
                fineCnt_r <= 12'h000;
            end else begin
                fineCnt_r <= fineCnt_r + 12'h001;
            end
        end
    end

    // terminal counts; restart on enable so first unit is whole
    assign scanTick = scanCnt_r == 16'(SCAN_CYCLES - 1);
    assign fineTick = fineCnt_r == 12'(FINE_CYC - 1);

    // pause only when software asked for it and a message is busy
    // the count holds rather than restarts, so a long message only
    // stretches the settle time and never loses progress
    assign pauseNow = pauseOnMessage_r && messageBusy;

    // settle interval and gate by attachment state
    // defaults cover the attached states; only the unattached
    // state may switch to the coarse scan unit
    always_comb begin
        unitTick = fineTick;
        limit = messageSettleTime;
        holdGate = 1'b1;
        case (attachState)
            ATT_UNATTACHED: begin
                // coarse or fine unit per the select bit
                unitTick = unitSel_r ? fineTick : scanTick;
                limit = unattachedSettleTime;
            end
            ATT_WAIT: begin
                // open must persist for the whole interval
                holdGate = openSeen;
            end
            ATT_SOURCE, ATT_SINK: begin
                // detach detection uses the message interval
                limit = messageSettleTime;
            end
            default: begin
                // unknown code: freeze the filter
                holdGate = 1'b0;
            end
        endcase
    end

    // pin 1 filter; a set bit means voltage above the threshold
    // filter output is the value software reads while compEnable is high
    settle_filter u_pin1 (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .enable(compEnable),
        .pause(pauseNow),
        .hold(holdGate),
        .tick(unitTick),
        .limit(limit),
        .filterEn(settleFilterEnable1),
        .raw(p1Sync_r),
        .hits(hits1),
        .settled(settled1)
    );

    // pin 2 filter, same timing as pin 1
    settle_filter u_pin2 (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .enable(compEnable),
        .pause(pauseNow),
        .hold(holdGate),
        .tick(unitTick),
        .limit(limit),
        .filterEn(settleFilterEnable2),
        .raw(p2Sync_r),
        .hits(hits2),
        .settled(settled2)
    );

    // previous results for change detection
    // both sides freeze together with ce, so no false toggle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hits1Prev_r <= HITS_RST;
            hits2Prev_r <= HITS_RST;
        end else if (ce) begin
            hits1Prev_r <= hits1;
            hits2Prev_r <= hits2;
        end
    end

    // change status: a toggle sets, write one clears, set wins
    // the clear acts on the old value, so a bit that toggles in
    // the same cycle as its clear stays set
    always_comb begin
        chg1_nxt = chg1_r;
        chg2_nxt = chg2_r;
        if (wrHit(ADDR_CHG1)) begin
            chg1_nxt = chg1_nxt & ~regWrData[7:0];
        end
        if (wrHit(ADDR_CHG2)) begin
            chg2_nxt = chg2_nxt & ~regWrData[7:0];
        end
        chg1_nxt = chg1_nxt | (hits1 ^ hits1Prev_r);
        chg2_nxt = chg2_nxt | (hits2 ^ hits2Prev_r);
    end

    // change status registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            chg1_r <= CHG_RST;
            chg2_r <= CHG_RST;
        end else if (ce) begin
            chg1_r <= chg1_nxt;
            chg2_r <= chg2_nxt;
        end
    end

    // first valid: set once per enable, dropped when disabled
    // filtered pins report on their first settled load; a fully
    // raw pin 1 has nothing to wait for once the filter runs; pin 2 is not checked
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            firstValid_r <= 1'b0;
        end else if (ce) begin
            if (!compEnable) begin
                firstValid_r <= 1'b0;
            end else if (settled1 || settled2) begin
                firstValid_r <= 1'b1;
            end else if (dbActive_r) begin
                // all pin 1 bits raw: first presented value is valid
                if (settleFilterEnable1 == 8'h00) begin
                    firstValid_r <= 1'b1;
                end
            end
        end
    end

    // status levels seen by software
    // attached covers both attached roles, not the wait state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dbActive_r <= 1'b0;
            attached_r <= 1'b0;
        end else if (ce) begin
            // lags enable by one cycle so polling is safe
            dbActive_r <= compEnable;
            attached_r <= attachState == ATT_SOURCE ||
                attachState == ATT_SINK;
        end
    end

    // read select; unmapped addresses read zero
    // reserved bits read zero; the low control byte is storage only
    always_comb begin
        rdMux = RD_NONE;
        case (regAddr)
            ADDR_HW_CTL: begin
                rdMux[POS_PAUSE] = pauseOnMessage_r;
                rdMux[POS_UNIT] = unitSel_r;
                rdMux[POS_DB_ACTIVE] = dbActive_r;
                rdMux[POS_ATTACHED] = attached_r;
                rdMux[7:0] = spare_r;
            end
            ADDR_SUMMARY: begin
                rdMux[POS_FIRST_VALID] = firstValid_r;
                // level follows change status, gone once cleared
                rdMux[POS_PIN2_CHG] = |chg2_r;
                rdMux[POS_PIN1_CHG] = |chg1_r;
            end
            ADDR_CHG1: begin
                rdMux[7:0] = chg1_r;
            end
            ADDR_CHG2: begin
                rdMux[7:0] = chg2_r;
            end
            ADDR_HITS1: begin
                rdMux[7:0] = hitsView(hits1);
            end
            ADDR_HITS2: begin
                rdMux[7:0] = hitsView(hits2);
            end
            default: begin
                rdMux = RD_NONE;
            end
        endcase
    end

    // read data held until the next read
    // a read strobe seen while ce is low is not taken
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdData_r <= RD_NONE;
        end else if (ce) begin
            if (regRdEn) begin
                rdData_r <= rdMux;
            end
        end
    end

    assign regRdData = rdData_r;
    assign pauseOnMessage = pauseOnMessage_r;
    assign debouncerActive = dbActive_r;
endmodule

// [cc_comparator_model.sv]
// comparator model for both pins: eight rising thresholds each
`timescale 1ns/1ps
module cc_comparator_model #(
    parameter int STEP = 20 // spacing of the programmed threshold levels
) (
    input wire logic [7:0] level1,
    input wire logic [7:0] level2,
    output logic [7:0] pin1Compare,
    output logic [7:0] pin2Compare
);
    // bit i trips only when the level is strictly above threshold i
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin1Compare[i] = int'(level1) > STEP * (i + 1);
            pin2Compare[i] = int'(level2) > STEP * (i + 1);
        end
    end
endmodule

// [cc_match_status_props.sv]
// port assertions for the threshold match status block
`timescale 1ns/1ps
module cc_match_status_props #(
    parameter int SCAN_CYCLES = cc_match_pkg::SCAN_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [11:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic compEnable,
    input wire cc_match_pkg::attach_t attachState,
    input wire logic pauseOnMessage,
    input wire logic debouncerActive
);
    import cc_match_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // address outside the six mapped places
    logic unmapped;
    assign unmapped = !(regAddr inside {ADDR_HW_CTL, ADDR_SUMMARY,
        ADDR_CHG1, ADDR_CHG2, ADDR_HITS1, ADDR_HITS2});
    debouncer_active_a: assert property ($past(ce) |->
        debouncerActive == $past(compEnable))
        else $error("debouncer active does not follow enable");
    pause_follow_a: assert property (
        ce && regWrEn && regAddr == ADDR_HW_CTL |=>
        pauseOnMessage == $past(regWrData[POS_PAUSE]))
        else $error("pause bit not written");
    pause_hold_a: assert property (
        !(ce && regWrEn && regAddr == ADDR_HW_CTL) |=> $stable(pauseOnMessage))
        else $error("pause bit changed without a write");
    unmapped_read_a: assert property (
        ce && regRdEn && unmapped |=> regRdData == RD_NONE)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!(ce && regRdEn) |=>
        $stable(regRdData))
        else $error("read data moved without a read");
    hits_disabled_a: assert property (
        ce && regRdEn && (regAddr == ADDR_HITS1 || regAddr == ADDR_HITS2)
        && !compEnable && !$past(compEnable) && !$past(compEnable, 2)
        |=> regRdData == RD_NONE)
        else $error("match read not default while disabled");
    hwctl_read_a: assert property (
        ce && regRdEn && regAddr == ADDR_HW_CTL |=>
        regRdData[15:13] == 3'h0 && !regRdData[10] &&
        regRdData[12] == $past(pauseOnMessage) &&
        regRdData[9] == $past(debouncerActive))
        else $error("control read fields wrong");
    attach_read_a: assert property (
        ce && regRdEn && regAddr == ADDR_HW_CTL && $stable(attachState) |=>
        regRdData[8] == ($past(attachState) inside {ATT_SOURCE, ATT_SINK}))
        else $error("attach bit wrong");
    summary_reserved_a: assert property (
        ce && regRdEn && regAddr == ADDR_SUMMARY |=> regRdData[6:2] == 5'h00)
        else $error("summary reserved bits set");
endmodule

bind cc_match_status cc_match_status_props #(.SCAN_CYCLES(SCAN_CYCLES))
    cc_match_status_props_i (.clk_sys, .nrst, .ce, .regAddr, .regWrEn,
    .regRdEn, .regWrData, .regRdData, .compEnable, .attachState,
    .pauseOnMessage, .debouncerActive);

// [cc_match_status_tb.sv]
// self-checking bench for the threshold match status block
`timescale 1ns/1ps
module cc_match_status_tb;
    import cc_match_pkg::*;
    localparam int SCAN = 20; // short scan keeps the coarse unit cheap
    localparam int FINE = 2500; // fine unit in cycles, fixed by design
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1; // clock enable, dropped once to show the freeze
    logic [11:0] regAddr = 12'h000;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] regRdData;
    logic [7:0] level1 = 8'h00; // pin levels seen by the comparators
    logic [7:0] level2 = 8'h00;
    logic [7:0] pin1Compare;
    logic [7:0] pin2Compare;
    logic compEnable = 1'b0;
    logic messageBusy = 1'b0;
    logic openSeen = 1'b0;
    attach_t attachState = ATT_UNATTACHED;
    logic [7:0] unattachedSettleTime = 8'h02;
    logic [7:0] messageSettleTime = 8'h00; // one fine tick
    logic [7:0] settleFilterEnable1 = 8'h00; // raw at first
    logic [7:0] settleFilterEnable2 = 8'h00;
    logic pauseOnMessage;
    logic debouncerActive;
    int mismatches = 0;
    int comparisons = 0;

    always #20 clk_sys = ~clk_sys;

    cc_comparator_model cc_comparator_model_i (.level1, .level2,
        .pin1Compare, .pin2Compare);
    cc_match_status #(.SCAN_CYCLES(SCAN)) cc_match_status_i (.clk_sys, .nrst,
        .ce, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
        .pin1Compare, .pin2Compare, .compEnable, .messageBusy, .openSeen,
        .attachState, .unattachedSettleTime, .messageSettleTime,
        .settleFilterEnable1, .settleFilterEnable2, .pauseOnMessage,
        .debouncerActive);

    // four-state compare, counted
    task automatic check(input logic [15:0] act, input logic [15:0] exp);
        comparisons++;
        if (act !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // strobe held over one rising edge; extra cycle avoids re-raise clash
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        cyc(1);
        regWrEn = 1'b0;
        cyc(1);
    endtask
    // data picked up one and a half cycles after the taking edge
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        cyc(1);
        regRdEn = 1'b0;
        cyc(1);
        d = regRdData;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        check(d, e);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        logic [15:0] got;
        int u;
        cyc(16);
        nrst = 1'b1;
        cyc(1);
        // reset values, unmapped place, read-only bits
        rdchk(ADDR_HW_CTL, 16'h0000);
        rdchk(ADDR_SUMMARY, 16'h0000);
        rdchk(ADDR_CHG1, 16'h0000);
        rdchk(ADDR_CHG2, 16'h0000);
        rdchk(ADDR_HITS2, 16'h0000);
        wr(12'h802, 16'hFFFF);
        rdchk(12'h802, 16'h0000);
        wr(ADDR_HW_CTL, 16'hFFFF);
        rdchk(ADDR_HW_CTL, 16'h18FF);
        wr(ADDR_HW_CTL, 16'h0000);
        $display("test reset done");
        // raw path, change flags and write-one clear
        compEnable = 1'b1;
        attachState = ATT_SOURCE;
        cyc(3);
        rdchk(ADDR_HW_CTL, 16'h0300);
        level1 = 8'd90;
        level2 = 8'd170;
        cyc(6);
        rdchk(ADDR_HITS1, 16'h000F);
        rdchk(ADDR_HITS2, 16'h00FF);
        rdchk(ADDR_CHG1, 16'h000F);
        rdchk(ADDR_SUMMARY, 16'h0083);
        wr(ADDR_CHG1, 16'h0005);
        rdchk(ADDR_CHG1, 16'h000A);
        wr(ADDR_CHG1, 16'h000A);
        rdchk(ADDR_SUMMARY, 16'h0082);
        wr(ADDR_CHG2, 16'h00FF);
        rdchk(ADDR_SUMMARY, 16'h0080);
        $display("test raw done");
        // unattached settle in both units
        attachState = ATT_UNATTACHED;
        settleFilterEnable1 = 8'hFF;
        for (int s = 0; s < 2; s++) begin
            u = s ? FINE : SCAN;
            wr(ADDR_HW_CTL, s ? 16'h0800 : 16'h0000);
            level1 = s ? 8'd90 : 8'd30;
            cyc(2 * u - 4);
            rdchk(ADDR_HITS1, s ? 16'h0001 : 16'h000F);
            cyc(2 * u + 30);
            rdchk(ADDR_HITS1, s ? 16'h000F : 16'h0001);
        end
        $display("test units done");
        // pause while the message path is busy
        wr(ADDR_HW_CTL, 16'h1800);
        check({15'h0000, pauseOnMessage}, 16'h0001);
        messageBusy = 1'b1;
        level1 = 8'd30;
        cyc(4 * FINE);
        rdchk(ADDR_HITS1, 16'h000F);
        messageBusy = 1'b0;
        cyc(4 * FINE);
        rdchk(ADDR_HITS1, 16'h0001);
        $display("test pause done");
        // clock enable low: a write is not taken
        ce = 1'b0;
        wr(ADDR_HW_CTL, 16'h0000);
        ce = 1'b1;
        rdchk(ADDR_HW_CTL, 16'h1A00);
        $display("test enable done");
        // attached and attach-wait settling, traffic with pause off
        wr(ADDR_HW_CTL, 16'h0800);
        check({15'h0000, pauseOnMessage}, 16'h0000);
        messageBusy = 1'b1;
        attachState = ATT_SINK;
        level1 = 8'd90;
        cyc(2 * FINE + 10);
        rdchk(ADDR_HITS1, 16'h000F);
        attachState = ATT_WAIT;
        level1 = 8'd30;
        cyc(2 * FINE + 10);
        rdchk(ADDR_HITS1, 16'h000F);
        openSeen = 1'b1;
        cyc(2 * FINE + 10);
        rdchk(ADDR_HITS1, 16'h0001);
        messageBusy = 1'b0;
        $display("test attach done");
        // disable, poll the active bit under a bound
        compEnable = 1'b0;
        got = 16'hFFFF;
        for (int k = 0; k < 8 && got[9] !== 1'b0; k++)
            rd(ADDR_HW_CTL, got);
        if (got[9] !== 1'b0) begin
            mismatches++;
            $display("ERROR %0t: debouncer never went idle", $time);
            stop_test();
        end
        rdchk(ADDR_HITS1, 16'h0000);
        $display("test disable done");
        stop_test();
    end
endmodule
